//--- verilog/psm_flag_mirror.sv
// summary status flag mirror: bits 13 down to 5 of the summary status word
// assumes the management frame decoder hands over one-cycle read strobes on
// clk_sys and that all source flags come from logic on the same clock
//
// How it works
// - polarity bit: one inverted, zero correct
// - polarity bit copies ten-base register bit four
// - ten-base read clears it, summary read keeps
// - false carrier latches high until counter read
// - false carrier counter read clears the latch
// - signal detect active high, latches low
// - descrambler lock active high, latches low
// - page received mirrors expansion, cleared there
// - interrupt bit set while any interrupt pends
// - interrupt source read clears pending bit
// - remote fault set on partner fault report
// - remote fault cleared by status read, reset
// - jabber copies basic status, summary read keeps
// - receive error latches until error counter read
`include "psm_consts.svh"
`timescale 1ns/1ps

module psm_flag_mirror (
    input  wire logic              clk_sys,           // 40 mhz system clock
    input  wire logic              rst,               // async reset, active high
    input  wire logic              rd_strobe,         // one-cycle register read
    input  wire psm_pkg::psm_addr_t rd_addr,          // address of that read
    input  wire logic              rx_err_evt,        // receive error pulse
    input  wire logic              pol_inverted,      // live polarity inverted
    input  wire logic              false_carrier_evt, // false carrier pulse
    input  wire logic              sig_detect,        // live 100 signal detect
    input  wire logic              descr_lock,        // live descrambler lock
    input  wire logic              page_rx_evt,       // new page received pulse
    input  wire logic              int_pending,       // any interrupt pending
    input  wire logic              remote_fault_evt,  // partner fault report
    input  wire logic              jabber,            // basic status jabber bit
    output logic                   rd_valid,          // summary read answer
    output psm_pkg::psm_data_t     rd_data            // summary word snapshot
);
    import psm_pkg::*;

    // ************************************************************
    // decode helpers
    // ************************************************************

    // read of one given register in this cycle
    function automatic logic is_read(input logic stb, input psm_addr_t a, input psm_addr_t target);
        is_read = stb && (a == target);
    endfunction : is_read

    // register whose read clears each latch-high flag
    function automatic psm_addr_t lh_clear_addr(input int idx);
        case (idx)
            0:       lh_clear_addr = `PSM_ADDR_RX_ERROR;
            1:       lh_clear_addr = `PSM_ADDR_TENBASE;
            2:       lh_clear_addr = `PSM_ADDR_FALSE_CARRIER;
            3:       lh_clear_addr = `PSM_ADDR_NEG_EXPANSION;
            4:       lh_clear_addr = `PSM_ADDR_INT_SOURCE;
            5:       lh_clear_addr = `PSM_ADDR_BASIC_STATUS;
            default: lh_clear_addr = `PSM_ADDR_SUMMARY;
        endcase
    endfunction : lh_clear_addr

    // ************************************************************
    // latch-high flags
    // ************************************************************

    psm_lh_t lh_set;   // set condition per flag
    psm_lh_t lh_q;     // latched flags
    logic    sum_read; // summary register read this cycle

    // summary read clears none of the latch-high flags
    assign sum_read = is_read(rd_strobe, rd_addr, `PSM_ADDR_SUMMARY);

    // flag order: rx error, polarity, false carrier, page, interrupt, fault
    assign lh_set = {remote_fault_evt,
                     int_pending,
                     page_rx_evt,
                     false_carrier_evt,
                     pol_inverted,
                     rx_err_evt};

    genvar gi;
    generate
        for (gi = 0; gi < 6; gi++) begin : g_lh
            logic next_flag; // next value of this flag
            logic clr;       // clearing read seen

            // set beats clear so an event in the clearing cycle survives
            always_comb begin
                clr       = is_read(rd_strobe, rd_addr, lh_clear_addr(gi));
                next_flag = lh_q[gi];
                if (lh_set[gi]) begin
                    next_flag = 1'b1;
                end else if (clr) begin
                    next_flag = 1'b0;
                end
            end

            // only reset and the owning read clear it
            always_ff @(posedge clk_sys or posedge rst) begin
                if (rst) begin
                    lh_q[gi] <= `PSM_RST_FLAG;
                end else begin
                    lh_q[gi] <= next_flag;
                end
            end
        end
    endgenerate

    // ************************************************************
    // latch-low flags
    // ************************************************************

    psm_ll_t ll_live; // live source levels
    psm_ll_t ll_q;    // latched-low flags

    // flag order: signal detect, descrambler lock
    assign ll_live = {descr_lock, sig_detect};

    generate
        for (gi = 0; gi < 2; gi++) begin : g_ll
            logic next_flag; // next value of this flag

            // a drop sticks until software has seen it in a summary read
            always_comb begin
                if (sum_read) begin
                    next_flag = ll_live[gi];
                end else begin
                    next_flag = ll_q[gi] & ll_live[gi];
                end
            end

            // starts low so the first summary read arms it
            always_ff @(posedge clk_sys or posedge rst) begin
                if (rst) begin
                    ll_q[gi] <= `PSM_RST_FLAG;
                end else begin
                    ll_q[gi] <= next_flag;
                end
            end
        end
    endgenerate

    // ************************************************************
    // jabber copy
    // ************************************************************

    logic jab_q;      // registered jabber copy
    logic next_jab;   // next jabber copy

    // plain copy, no read touches it
    always_comb begin
        next_jab = jabber;
    end

    // one cycle behind the basic status bit
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            jab_q <= `PSM_RST_FLAG;
        end else begin
            jab_q <= next_jab;
        end
    end

    // ************************************************************
    // read answer
    // ************************************************************

    logic      next_rd_valid; // next answer strobe
    psm_data_t next_rd_data;  // next answer word

    // snapshot is taken before this cycle's clears take effect
    always_comb begin
        next_rd_valid = sum_read;
        next_rd_data  = `PSM_RST_DATA;
        if (sum_read) begin
            next_rd_data[`PSM_BIT_RX_ERROR]      = lh_q[0];
            next_rd_data[`PSM_BIT_POLARITY]      = lh_q[1];
            next_rd_data[`PSM_BIT_FALSE_CARRIER] = lh_q[2];
            next_rd_data[`PSM_BIT_SIGNAL_DETECT] = ll_q[0];
            next_rd_data[`PSM_BIT_DESCR_LOCK]    = ll_q[1];
            next_rd_data[`PSM_BIT_PAGE_RX]       = lh_q[3];
            next_rd_data[`PSM_BIT_INT_PENDING]   = lh_q[4];
            next_rd_data[`PSM_BIT_REMOTE_FAULT]  = lh_q[5];
            next_rd_data[`PSM_BIT_JABBER]        = jab_q;
        end
    end

    // data holds only in the answer cycle, zero otherwise
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rd_valid <= 1'b0;
            rd_data  <= `PSM_RST_DATA;
        end else begin
            rd_valid <= next_rd_valid;
            rd_data  <= next_rd_data;
        end
    end

    // ************************************************************
    // assertions
    // ************************************************************

    // polarity answer carries the copy held at read time
    a_pol_report: assert property (@(posedge clk_sys) disable iff (rst)
        sum_read |=> rd_valid && (rd_data[`PSM_BIT_POLARITY] == $past(lh_q[1])))
        else $error("polarity bit not reported");

    // inverted polarity reaches the copy next cycle
    a_pol_copy: assert property (@(posedge clk_sys) disable iff (rst)
        pol_inverted |=> lh_q[1])
        else $error("polarity copy missed");

    // ten-base read clears, summary read keeps
    a_pol_clear: assert property (@(posedge clk_sys) disable iff (rst)
        (is_read(rd_strobe, rd_addr, `PSM_ADDR_TENBASE) && !pol_inverted) |=> !lh_q[1])
        else $error("polarity copy not cleared");
    a_pol_keep: assert property (@(posedge clk_sys) disable iff (rst)
        (sum_read && lh_q[1]) |=> lh_q[1])
        else $error("polarity copy lost on summary read");

    // false carrier holds until its counter is read
    a_fc_hold: assert property (@(posedge clk_sys) disable iff (rst)
        (lh_q[2] && !is_read(rd_strobe, rd_addr, `PSM_ADDR_FALSE_CARRIER)) |=> lh_q[2])
        else $error("false carrier latch dropped");
    a_fc_clear: assert property (@(posedge clk_sys) disable iff (rst)
        (is_read(rd_strobe, rd_addr, `PSM_ADDR_FALSE_CARRIER) && !false_carrier_evt) |=> !lh_q[2])
        else $error("false carrier latch not cleared");

    // lost signal or lock stays low until a summary read
    a_sd_low: assert property (@(posedge clk_sys) disable iff (rst)
        (!sig_detect && !sum_read) |=> !ll_q[0] ##1 (!ll_q[0] || $past(sum_read)))
        else $error("signal detect did not latch low");
    a_lock_low: assert property (@(posedge clk_sys) disable iff (rst)
        !descr_lock |=> !ll_q[1])
        else $error("descrambler lock did not latch low");

    // page mirror cleared only by its own register
    a_page_keep: assert property (@(posedge clk_sys) disable iff (rst)
        (sum_read && lh_q[3]) |=> lh_q[3])
        else $error("page flag cleared by summary read");

    // pending interrupt shows, source read clears
    a_int_set: assert property (@(posedge clk_sys) disable iff (rst)
        int_pending |=> lh_q[4])
        else $error("pending interrupt not shown");
    a_int_clear: assert property (@(posedge clk_sys) disable iff (rst)
        (is_read(rd_strobe, rd_addr, `PSM_ADDR_INT_SOURCE) && !int_pending) |=> !lh_q[4])
        else $error("interrupt flag not cleared");

    // remote fault set by report, cleared by basic status read
    a_rf_set: assert property (@(posedge clk_sys) disable iff (rst)
        remote_fault_evt |=> lh_q[5])
        else $error("remote fault not latched");
    a_rf_clear: assert property (@(posedge clk_sys) disable iff (rst)
        (is_read(rd_strobe, rd_addr, `PSM_ADDR_BASIC_STATUS) && !remote_fault_evt) |=> !lh_q[5])
        else $error("remote fault not cleared");

    // jabber reaches the answer two cycles on
    a_jab_copy: assert property (@(posedge clk_sys) disable iff (rst)
        (sum_read && !$past(rst)) |=> (rd_data[`PSM_BIT_JABBER] == $past(jabber, 2)))
        else $error("jabber copy wrong");
    a_jab_follow: assert property (@(posedge clk_sys) disable iff (rst)
        1'b1 |=> (jab_q == $past(jabber)))
        else $error("jabber copy not following");

    // receive error set and cleared by its counter read
    a_rxerr_set: assert property (@(posedge clk_sys) disable iff (rst)
        rx_err_evt |=> lh_q[0])
        else $error("receive error not latched");
    a_rxerr_clear: assert property (@(posedge clk_sys) disable iff (rst)
        (is_read(rd_strobe, rd_addr, `PSM_ADDR_RX_ERROR) && !rx_err_evt) |=> !lh_q[0])
        else $error("receive error not cleared");

    // summary read rearms latched-low flags to live value
    a_ll_rearm: assert property (@(posedge clk_sys) disable iff (rst)
        (sum_read && sig_detect && descr_lock) |=> (ll_q == 2'b11))
        else $error("latched-low flags not rearmed");

    // main scenarios
    c_sd_drop_read: cover property (@(posedge clk_sys) disable iff (rst)
        !sig_detect ##1 sig_detect ##1 sum_read);
    c_fc_set_clear: cover property (@(posedge clk_sys) disable iff (rst)
        false_carrier_evt ##[1:8] is_read(rd_strobe, rd_addr, `PSM_ADDR_FALSE_CARRIER));
    c_rf_clear: cover property (@(posedge clk_sys) disable iff (rst)
        lh_q[5] ##1 is_read(rd_strobe, rd_addr, `PSM_ADDR_BASIC_STATUS) ##1 !lh_q[5]);
    c_set_wins: cover property (@(posedge clk_sys) disable iff (rst)
        int_pending && is_read(rd_strobe, rd_addr, `PSM_ADDR_INT_SOURCE));

endmodule : psm_flag_mirror

//--- pkg/psm_consts.svh
// constants of the summary status flag mirror: offsets, bit positions, resets
// assumes 5-bit management register addresses and 16-bit register data
`ifndef PSM_CONSTS_SVH
`define PSM_CONSTS_SVH
// register offsets on the management port
`define PSM_ADDR_BASIC_STATUS   5'h01
`define PSM_ADDR_NEG_EXPANSION  5'h06
`define PSM_ADDR_SUMMARY        5'h10
`define PSM_ADDR_INT_SOURCE     5'h12
`define PSM_ADDR_FALSE_CARRIER  5'h14
`define PSM_ADDR_RX_ERROR       5'h15
`define PSM_ADDR_TENBASE        5'h1a
// bit positions inside the summary status word
`define PSM_BIT_RX_ERROR        4'hd
`define PSM_BIT_POLARITY        4'hc
`define PSM_BIT_FALSE_CARRIER   4'hb
`define PSM_BIT_SIGNAL_DETECT   4'ha
`define PSM_BIT_DESCR_LOCK      4'h9
`define PSM_BIT_PAGE_RX         4'h8
`define PSM_BIT_INT_PENDING     4'h7
`define PSM_BIT_REMOTE_FAULT    4'h6
`define PSM_BIT_JABBER          4'h5
// reset values
`define PSM_RST_FLAG            1'h0
`define PSM_RST_DATA            16'h0000
`endif

//--- pkg/psm_pkg.sv
// types shared by the summary status flag mirror
// assumes the constants header sits beside it
package psm_pkg;
    typedef logic [4:0]  psm_addr_t;  // management register address
    typedef logic [15:0] psm_data_t;  // management register data
    typedef logic [5:0]  psm_lh_t;    // one bit per latch-high flag
    typedef logic [1:0]  psm_ll_t;    // one bit per latch-low flag
endpackage : psm_pkg

//--- tb/tb.sv
// bench for the summary status flag mirror: read sequences against expected words
// assumes the constants header and package are compiled first, one clock, no partner
`include "psm_consts.svh"
`timescale 1ns/1ps

module tb;
    import psm_pkg::*;

    // ****************************************
    // signals and bookkeeping
    // ****************************************
    logic      clk_sys;      // 40 mhz bench clock
    logic      rst;          // async reset, active high
    logic      rd_strobe;    // read request strobe
    psm_addr_t rd_addr;      // read address
    logic [5:0] src;         // latch-high sources, one bit each
    logic      sig_detect;   // live signal detect
    logic      descr_lock;   // live descrambler lock
    logic      jabber;       // live jabber level
    logic      rd_valid;     // answer strobe from the mirror
    psm_data_t rd_data;      // answer word
    logic      seen_v;       // answer strobe captured by rd
    psm_data_t seen_d;       // answer word captured by rd
    int        n_mismatch;   // failed comparisons
    int        checked;      // comparisons made
    int        cyc;          // cycles since start, for the hang guard
    int        bit_p [6];    // summary bit of each source
    psm_addr_t clr_a [6];    // register whose read clears that bit

    psm_flag_mirror i_dut (
        .clk_sys           (clk_sys),
        .rst               (rst),
        .rd_strobe         (rd_strobe),
        .rd_addr           (rd_addr),
        .rx_err_evt        (src[0]),
        .pol_inverted      (src[1]),
        .false_carrier_evt (src[2]),
        .sig_detect        (sig_detect),
        .descr_lock        (descr_lock),
        .page_rx_evt       (src[3]),
        .int_pending       (src[4]),
        .remote_fault_evt  (src[5]),
        .jabber            (jabber),
        .rd_valid          (rd_valid),
        .rd_data           (rd_data)
    );

    // ****************************************
    // clock and hang guard
    // ****************************************
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    // the whole run needs about 110 cycles; a stuck read never ends
    always @(posedge clk_sys) begin
        cyc = cyc + 1;
        if (cyc == 2000) begin
            n_mismatch = n_mismatch + 1;
            close_out();
        end
    end

    // ****************************************
    // shared tasks
    // ****************************************
    // compare and count; unknowns never match
    task automatic chk(input psm_data_t seen, input psm_data_t exp, input string what);
        checked = checked + 1;
        if (seen !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : chk

    // one read: strobe for one edge, answer looked at one cycle later
    task automatic rd(input psm_addr_t a);
        @(posedge clk_sys);
        rd_strobe <= 1'b1;
        rd_addr   <= a;
        @(posedge clk_sys);
        rd_strobe <= 1'b0;
        #1;
        seen_v = rd_valid;
        seen_d = rd_data;
    endtask : rd

    // summary read with full word compare, reserved bits included
    task automatic summ(input psm_data_t exp);
        rd(`PSM_ADDR_SUMMARY);
        chk({15'h0000, seen_v}, 16'h0001, "answer strobe");
        chk(seen_d, exp, "summary word");
    endtask : summ

    // one-cycle source pulse; level sources drop again afterwards
    task automatic pulse(input int i);
        @(posedge clk_sys);
        src[i] <= 1'b1;
        @(posedge clk_sys);
        src[i] <= 1'b0;
    endtask : pulse

    // counts line, verdict, end of run
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : close_out

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        n_mismatch = 0;
        checked    = 0;
        cyc        = 0;
        bit_p      = '{13, 12, 11, 8, 7, 6};
        clr_a      = '{`PSM_ADDR_RX_ERROR, `PSM_ADDR_TENBASE, `PSM_ADDR_FALSE_CARRIER,
                       `PSM_ADDR_NEG_EXPANSION, `PSM_ADDR_INT_SOURCE, `PSM_ADDR_BASIC_STATUS};
        rst        = 1'b1;
        rd_strobe  = 1'b0;
        rd_addr    = 5'h00;
        src        = 6'h00;
        sig_detect = 1'b1;
        descr_lock = 1'b1;
        jabber     = 1'b0;
        repeat (5) @(posedge clk_sys);
        rst <= 1'b0;

        // latch-low flags start at zero and rearm on the first summary read
        summ(16'h0000);
        summ(16'h0600);
        $display("test latch_low_rearm done");

        // a short loss stays visible until read, then the live value returns
        @(posedge clk_sys) sig_detect <= 1'b0;
        @(posedge clk_sys) sig_detect <= 1'b1;
        summ(16'h0200);
        summ(16'h0600);
        @(posedge clk_sys) descr_lock <= 1'b0;
        @(posedge clk_sys) descr_lock <= 1'b1;
        summ(16'h0400);
        summ(16'h0600);
        $display("test latch_low_loss done");

        // every latch-high flag: set, survives summary reads, cleared by its own register
        for (int i = 0; i < 6; i++) begin
            pulse(i);
            summ(16'h0600 | (16'h0001 << bit_p[i]));
            summ(16'h0600 | (16'h0001 << bit_p[i]));
            rd(clr_a[i]);
            chk({15'h0000, seen_v}, 16'h0000, "no answer to other register");
            summ(16'h0600);
        end
        $display("test latch_high_clear done");

        // a pending level keeps its flag through its own clearing read
        @(posedge clk_sys) src[4] <= 1'b1;
        rd(`PSM_ADDR_INT_SOURCE);
        summ(16'h0680);
        @(posedge clk_sys) src[4] <= 1'b0;
        rd(`PSM_ADDR_INT_SOURCE);
        summ(16'h0600);
        $display("test set_wins done");

        // jabber is a plain copy that a summary read does not clear
        @(posedge clk_sys) jabber <= 1'b1;
        summ(16'h0620);
        summ(16'h0620);
        @(posedge clk_sys) jabber <= 1'b0;
        summ(16'h0600);
        $display("test jabber_copy done");

        // reset in mid-run drops a remote fault and the latch-low flags
        pulse(5);
        @(posedge clk_sys) rst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        summ(16'h0000);
        summ(16'h0600);
        $display("test mid_reset done");

        close_out();
    end

endmodule : tb
